/* File: design/ettmr_pkg.sv */
/*
  package for the eight-bit trigger timer: register offsets, field
  positions, reset values, clear and output action codes and prescaler ratios.
  assumes a 32-bit ahb-lite register bus with word-aligned registers.
*/
package ettmr_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_MAIN_CTRL = 8'h00;
  localparam logic [7:0] OFS_TRIG_CTRL = 8'h04;
  localparam logic [7:0] OFS_CTRL_STAT = 8'h08;
  localparam logic [7:0] OFS_COUNT = 8'h0c;
  localparam logic [7:0] OFS_CMP_A = 8'h10;
  localparam logic [7:0] OFS_CMP_B = 8'h14;

  // main_timer_control fields
  localparam int MC_MIEB = 7;
  localparam int MC_MIEA = 6;
  localparam int MC_OVERFLOW_IRQ_ENABLE = 5;
  localparam int MC_CLR_HI = 4;
  localparam int MC_CLR_LO = 3;
  localparam int MC_CKS_LO = 0;

  // trigger_clock_control fields
  localparam int TC_EDGE_LO = 3;
  localparam int TC_TRIGGER_START_ENABLE = 2;
  localparam int TC_ICKS = 0;
  localparam logic [7:0] TC_RSVD_ONES = 8'he2;

  // timer_ctrl_status fields
  localparam int CS_FLAG_B = 7;
  localparam int CS_FLAG_A = 6;
  localparam int CS_FLAG_OV = 5;
  localparam int CS_OS_B_LO = 2;
  localparam int CS_OS_A_LO = 0;

  // reset values and counter maximum
  localparam logic [7:0] RST_COUNT = 8'h00;
  localparam logic [7:0] RST_CMP = 8'hff;
  localparam logic [7:0] CNT_MAX = 8'hff;

  // counter clear selection
  localparam logic [1:0] CLR_NONE = 2'h0;
  localparam logic [1:0] CLR_MATCH_A = 2'h1;
  localparam logic [1:0] CLR_MATCH_B = 2'h2;
  localparam logic [1:0] CLR_PIN = 2'h3;

  // output action per match
  localparam logic [1:0] OUT_KEEP = 2'h0;
  localparam logic [1:0] OUT_ZERO = 2'h1;
  localparam logic [1:0] OUT_ONE = 2'h2;
  localparam logic [1:0] OUT_TOGGLE = 2'h3;

  // prescaler divide ratios, as powers of two
  localparam int DIV_A_LOG2 = 2;
  localparam int DIV_B_LOG2 = 4;
  localparam int DIV_C_LOG2 = 5;
  localparam int DIV_D_LOG2 = 6;
  localparam int DIV_E_LOG2 = 7;
  localparam int DIV_F_LOG2 = 8;
  localparam int PRE_W = 8;
endpackage

/* File: design/ettmr_sync_edge.sv */
/*
  two-flop synchroniser with rising and falling edge pulses.
  assumes the pin input is asynchronous to sys_clk.
*/
`timescale 1ns/1ns
module ettmr_sync_edge (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // pin and edges
  input wire logic pin_in,
  output logic level_out,
  output logic rise_out,
  output logic fall_out
);
  logic meta_ff;
  logic sync_ff;
  logic last_ff;

  // meta_ff feeds only sync_ff; edges come from later stages
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      last_ff <= 1'b0;
    end else begin
      meta_ff <= pin_in;
      sync_ff <= meta_ff;
      last_ff <= sync_ff;
    end
  end

  assign level_out = sync_ff;
  assign rise_out = sync_ff & ~last_ff;
  assign fall_out = ~sync_ff & last_ff;
endmodule

/* File: design/ettmr_prescaler.sv */
/*
  free-running prescaler giving one-cycle count enables.
  assumes a single sys_clk domain; the counter wraps freely.
*/
`timescale 1ns/1ns
module ettmr_prescaler
  import ettmr_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // tap enables, one per divide ratio
  output logic [5:0] tick
);
  logic [ettmr_pkg::PRE_W-1:0] div_ff;
  logic [ettmr_pkg::PRE_W-1:0] nxt_div;
  localparam int TAPS [6] = '{DIV_A_LOG2, DIV_B_LOG2, DIV_C_LOG2,
                              DIV_D_LOG2, DIV_E_LOG2, DIV_F_LOG2};

  assign nxt_div = div_ff + 8'h01;

  // free-running divider
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      div_ff <= 8'h00;
    end else begin
      div_ff <= nxt_div;
    end
  end

  // tick when the low bits of the divider roll over
  genvar g;
  generate
    for (g = 0; g < 6; g++) begin : g_tap
      assign tick[g] = &div_ff[TAPS[g]-1:0];
    end
  endgenerate
endmodule

/* File: design/ettmr_top.sv */
/*
  eight-bit trigger timer: counter, two compare registers, overflow and
  match flags with request outputs, waveform output, clear and trigger.
  assumes an ahb-lite master on sys_clk; pins are asynchronous.
*/
// The AHB-Lite interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ns
module ettmr_top
  import ettmr_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // pins
  input wire logic trigger_input_pin,
  input wire logic external_clear_pin,
  input wire logic ext_clock_pin,
  output logic waveform_output_pin,
  // requests to the cpu
  output logic overflow_irq,
  output logic match_irq_a,
  output logic match_irq_b
);
  import ettmr_pkg::*;

  logic [7:0] main_ctrl_ff;
  logic [7:0] trig_ctrl_ff;
  logic [3:0] out_sel_ff;
  logic [7:0] count_ff;
  logic [7:0] cmp_a_ff;
  logic [7:0] cmp_b_ff;
  logic ovf_ff;
  logic flag_a_ff;
  logic flag_b_ff;
  logic wave_ff;
  logic run_ff;
  logic eq_a_ff;
  logic eq_b_ff;
  logic wr_pend_ff;
  logic [7:0] wr_addr_ff;
  logic [31:0] rdata_ff;
  logic [5:0] tick;
  logic trig_rise, trig_fall, clr_rise, ext_rise, ext_fall;

  // pin synchronisers; no logic sees the raw pins
  // sync and edges
  ettmr_sync_edge u_trig (.sys_clk(sys_clk), .nrst(nrst),
    .pin_in(trigger_input_pin), .level_out(), .rise_out(trig_rise),
    .fall_out(trig_fall));
  ettmr_sync_edge u_clr (.sys_clk(sys_clk), .nrst(nrst),
    .pin_in(external_clear_pin), .level_out(), .rise_out(clr_rise),
    .fall_out());
  ettmr_sync_edge u_ext (.sys_clk(sys_clk), .nrst(nrst),
    .pin_in(ext_clock_pin), .level_out(), .rise_out(ext_rise),
    .fall_out(ext_fall));
  ettmr_prescaler u_pre (.sys_clk(sys_clk), .nrst(nrst), .tick(tick));

  // register field decode
  wire [1:0] edge_sel = trig_ctrl_ff[TC_EDGE_LO +: 2];
  wire trig_en = trig_ctrl_ff[TC_TRIGGER_START_ENABLE];
  wire icks = trig_ctrl_ff[TC_ICKS];
  wire [2:0] cks = main_ctrl_ff[MC_CKS_LO +: 3];
  wire [1:0] clr_sel = main_ctrl_ff[MC_CLR_LO +: 2];

  // clock source choice
  // clock select: cks with icks picks one of six taps or pin edges
  function automatic logic pick_clock(input logic [2:0] c, input logic i,
                                      input logic [5:0] t,
                                      input logic er, input logic ef);
    case (c)
      3'h1: pick_clock = i ? t[1] : t[0];
      3'h2: pick_clock = i ? t[3] : t[2];
      3'h3: pick_clock = i ? t[5] : t[4];
      3'h5: pick_clock = er;
      3'h6: pick_clock = ef;
      3'h7: pick_clock = er | ef;
      default: pick_clock = 1'b0;
    endcase
  endfunction

  wire trig_hit = (edge_sel == 2'h1 && trig_rise) ||
                  (edge_sel == 2'h2 && trig_fall) ||
                  (edge_sel == 2'h3 && (trig_rise | trig_fall));

  // bus address and write decode
  wire bus_take = hsel & hready & htrans[1];
  wire wr_now = wr_pend_ff;
  wire wr_main = wr_now && wr_addr_ff == OFS_MAIN_CTRL;
  wire wr_trig = wr_now && wr_addr_ff == OFS_TRIG_CTRL;
  wire wr_stat = wr_now && wr_addr_ff == OFS_CTRL_STAT;
  wire wr_cnt = wr_now && wr_addr_ff == OFS_COUNT;
  wire wr_cmpa = wr_now && wr_addr_ff == OFS_CMP_A;
  wire wr_cmpb = wr_now && wr_addr_ff == OFS_CMP_B;
  wire [7:0] wbyte = hwdata[7:0];

  // count on selected clock, gated by run state
  // without trigger enable the counter free-runs
  wire clk_en = pick_clock(cks, icks, tick, ext_rise, ext_fall);
  wire counting = trig_en ? run_ff : 1'b1;
  wire inc = clk_en & counting;

  // match lands on the last equal state, at the next increment
  wire eq_a = count_ff == cmp_a_ff;
  wire eq_b = count_ff == cmp_b_ff;
  // a compare register write inhibits its own match in that cycle
  wire match_a = eq_a & inc & ~wr_cmpa;
  wire match_b = eq_b & inc & ~wr_cmpb;

  wire clr_ev = (clr_sel == CLR_MATCH_A && match_a) ||
                (clr_sel == CLR_MATCH_B && match_b) ||
                (clr_sel == CLR_PIN && clr_rise);
  wire ovf_ev = inc & (count_ff == CNT_MAX) & ~clr_ev & ~wr_cnt;

  // clear beats a counter write, a write beats an increment
  wire [7:0] nxt_count = clr_ev ? RST_COUNT :
                         wr_cnt ? wbyte :
                         inc ? count_ff + 8'h01 : count_ff;

  // halt on clear, restart on edge
  wire nxt_run = trig_en & trig_hit ? 1'b1 :
                 trig_en & clr_ev ? 1'b0 : run_ff;

  // output action encoding; toggle beats one beats zero
  wire [1:0] act_a = match_a ? out_sel_ff[CS_OS_A_LO +: 2] : OUT_KEEP;
  wire [1:0] act_b = match_b ? out_sel_ff[CS_OS_B_LO +: 2] : OUT_KEEP;
  wire nxt_wave =
    (act_a == OUT_TOGGLE || act_b == OUT_TOGGLE) ? ~wave_ff :
    (act_a == OUT_ONE || act_b == OUT_ONE) ? 1'b1 :
    (act_a == OUT_ZERO || act_b == OUT_ZERO) ? 1'b0 : wave_ff;

  // flags: a hardware set wins over a software clear of zero
  wire nxt_ovf = ovf_ev | (wr_stat ? ovf_ff & wbyte[CS_FLAG_OV] : ovf_ff);
  wire nxt_fa = match_a |
                (wr_stat ? flag_a_ff & wbyte[CS_FLAG_A] : flag_a_ff);
  wire nxt_fb = match_b |
                (wr_stat ? flag_b_ff & wbyte[CS_FLAG_B] : flag_b_ff);

  // register data ahead of the read data phase
  // reserved trigger bits read one
  wire [7:0] trig_rd = trig_ctrl_ff | TC_RSVD_ONES;
  wire [7:0] stat_rd = {flag_b_ff, flag_a_ff, ovf_ff, 1'b0, out_sel_ff};
  wire [7:0] rd_byte = haddr == OFS_MAIN_CTRL ? main_ctrl_ff :
                       haddr == OFS_TRIG_CTRL ? trig_rd :
                       haddr == OFS_CTRL_STAT ? stat_rd :
                       haddr == OFS_COUNT ? count_ff :
                       haddr == OFS_CMP_A ? cmp_a_ff :
                       haddr == OFS_CMP_B ? cmp_b_ff : 8'h00;

  // bus phase capture; unmapped reads return zero, writes are dropped
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      rdata_ff <= 32'h0000_0000;
    end else begin
      wr_pend_ff <= bus_take & hwrite;
      if (bus_take) begin
        wr_addr_ff <= haddr;
      end
      if (bus_take & ~hwrite) begin
        rdata_ff <= {24'h00_0000, rd_byte};
      end
    end
  end

  // software registers
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      main_ctrl_ff <= 8'h00;
      trig_ctrl_ff <= 8'h00;
      out_sel_ff <= 4'h0;
      cmp_a_ff <= RST_CMP;
      cmp_b_ff <= RST_CMP;
    end else begin
      if (wr_main) main_ctrl_ff <= wbyte;
      if (wr_trig) trig_ctrl_ff <= wbyte & ~TC_RSVD_ONES;
      if (wr_stat) out_sel_ff <= wbyte[3:0];
      if (wr_cmpa) cmp_a_ff <= wbyte;
      if (wr_cmpb) cmp_b_ff <= wbyte;
    end
  end

  // counter, run state, flags and waveform
  // output starts at zero
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      count_ff <= RST_COUNT;
      run_ff <= 1'b0;
      ovf_ff <= 1'b0;
      flag_a_ff <= 1'b0;
      flag_b_ff <= 1'b0;
      wave_ff <= 1'b0;
      eq_a_ff <= 1'b0;
      eq_b_ff <= 1'b0;
    end else begin
      count_ff <= nxt_count;
      run_ff <= nxt_run;
      ovf_ff <= nxt_ovf;
      flag_a_ff <= nxt_fa;
      flag_b_ff <= nxt_fb;
      wave_ff <= nxt_wave;
      eq_a_ff <= eq_a;
      eq_b_ff <= eq_b;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_ff;
  assign waveform_output_pin = wave_ff;
  assign overflow_irq = ovf_ff & main_ctrl_ff[MC_OVERFLOW_IRQ_ENABLE];
  assign match_irq_a = flag_a_ff & main_ctrl_ff[MC_MIEA];
  assign match_irq_b = flag_b_ff & main_ctrl_ff[MC_MIEB];

  // overflow flag rises one cycle after the wrap
  ovf_set_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    ovf_ev |=> ovf_ff && count_ff == 8'h00)
    else $error("overflow flag not set on wrap");

  // match flag follows an equal state that ends by increment
  match_flag_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    match_a |=> flag_a_ff)
    else $error("match flag a not set");

  // match waits for the increment that leaves the equal value
  last_state_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    $rose(flag_a_ff) |-> $past(eq_a) && $past(inc))
    else $error("match flag set before last equal state");

  // clear by match returns counter to zero
  clr_match_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (clr_sel == CLR_MATCH_A && match_a) |=> count_ff == 8'h00)
    else $error("counter not cleared on match");

  // pin clear returns counter to zero
  clr_pin_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (clr_sel == CLR_PIN && clr_rise) |=> count_ff == 8'h00)
    else $error("counter not cleared by pin");

  // a clear with trigger enabled and no trigger edge halts the counter
  trig_halt_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (trig_en && clr_ev && !trig_hit) |=> !run_ff)
    else $error("counter kept running after clear");

  // reserved trigger bits reach the bus high on every read
  rsvd_ones_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (bus_take && !hwrite && haddr == OFS_TRIG_CTRL) |=>
      (hrdata[7:0] & TC_RSVD_ONES) == TC_RSVD_ONES)
    else $error("reserved bits not read as one");

  // a wrap with the enable set raises the request next cycle
  ovf_irq_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (ovf_ev && main_ctrl_ff[MC_OVERFLOW_IRQ_ENABLE] && !wr_main) |=> overflow_irq)
    else $error("overflow request missing");

  // toggle on match a flips output
  wave_tog_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (act_a == OUT_TOGGLE && act_b == OUT_KEEP) |=>
      waveform_output_pin != $past(waveform_output_pin))
    else $error("output did not toggle");
endmodule

/* File: verification/ettmr_pin_model.sv */
/*
  pin-side model of the timer: trigger, clear and count clock pins.
  assumes each task is entered just after a rising edge of sys_clk.
*/
`timescale 1ns/1ns
module ettmr_pin_model (
  // clock
  input wire logic sys_clk,
  // pins toward the timer
  output logic trig_pin,
  output logic clr_pin,
  output logic clk_pin
);
  // all pins idle low; the count clock stands still between bursts
  initial begin
    trig_pin = 1'b0;
    clr_pin = 1'b0;
    clk_pin = 1'b0;
  end
  // flip the trigger level, then give the synchroniser time
  task automatic tog_trig();
    trig_pin <= ~trig_pin;
    repeat (4) @(posedge sys_clk);
  endtask
  task automatic pulse_clr();
    clr_pin <= 1'b1;
    repeat (2) @(posedge sys_clk);
    clr_pin <= 1'b0;
    repeat (6) @(posedge sys_clk);
  endtask
  // three clocks high, three low, so two-flop sync sees every edge
  task automatic clk_burst(input int n);
    repeat (n) begin
      clk_pin <= 1'b1;
      repeat (3) @(posedge sys_clk);
      clk_pin <= 1'b0;
      repeat (3) @(posedge sys_clk);
    end
  endtask
endmodule

/* File: verification/tb_top.sv */
/*
  self-checking bench for the eight-bit trigger timer.
  assumes the zero-wait ahb-lite slave and the pin model beside it.
*/
`timescale 1ns/1ns
module tb_top;
  import ettmr_pkg::*;
  logic sys_clk, nrst, hsel, hwrite, hready, hreadyout, hresp;
  logic [7:0] haddr;
  logic [1:0] htrans, m;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, rv;
  logic trig, clr, eclk, wave, ov_irq, irq_a, irq_b, hit;
  int miscompares, samples_checked, cycles;
  logic [1:0] codes [5] = '{2'h2, 2'h1, 2'h3, 2'h3, 2'h0};
  logic expw [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
  logic [1:0] modes [4] = '{2'h2, 2'h3, 2'h1, 2'h0};
  logic [2:0] eck [3] = '{3'h5, 3'h6, 3'h7};
  logic [7:0] expc [3] = '{8'h04, 8'h04, 8'h08};

  // single slave, so its ready is the bus ready
  assign hready = hreadyout;

  ettmr_top dut (.sys_clk(sys_clk), .nrst(nrst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .trigger_input_pin(trig),
    .external_clear_pin(clr), .ext_clock_pin(eclk),
    .waveform_output_pin(wave), .overflow_irq(ov_irq),
    .match_irq_a(irq_a), .match_irq_b(irq_b));

  ettmr_pin_model pins (.sys_clk(sys_clk), .trig_pin(trig),
    .clr_pin(clr), .clk_pin(eclk));

  // 250 MHz system clock
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // hang guard: the tests need well under this many cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      conclude();
    end
  end

  task automatic conclude();
    if (miscompares == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one single transfer; entered just after a rising edge
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge sys_clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (hready !== 1'b1);
    rv = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, {24'h0, d});
  endtask

  task automatic rd_chk(input string name, input logic [7:0] a, e);
    bus(1'b0, a, 32'h0);
    check(name, rv, {24'h0, e});
  endtask

  // counter read must fall within lo..hi
  task automatic cnt_in(input string name, input logic [7:0] lo, hi);
    bus(1'b0, OFS_COUNT, 32'h0);
    check(name, {31'h0, (rv[7:0] >= lo && rv[7:0] <= hi)}, 32'h1);
  endtask

  initial begin
    nrst = 1'b0;
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    miscompares = 0;
    samples_checked = 0;
    cycles = 0;
    repeat (12) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    // reset state, reserved ones, unmapped place
    check("wave_rst", {31'h0, wave}, 32'h0);
    check("hresp", {31'h0, hresp}, 32'h0);
    rd_chk("trig_rst", OFS_TRIG_CTRL, 8'he2);
    rd_chk("cmp_rst", OFS_CMP_B, RST_CMP);
    wr(OFS_TRIG_CTRL, 8'hff);
    rd_chk("trig_ff", OFS_TRIG_CTRL, 8'hff);
    wr(OFS_TRIG_CTRL, 8'h00);
    rd_chk("trig_00", OFS_TRIG_CTRL, 8'he2);
    rd_chk("unmapped", 8'h1c, 8'h00);
    // overflow from fe at div4
    wr(OFS_CMP_A, 8'h05);
    wr(OFS_CMP_B, 8'h03);
    wr(OFS_COUNT, 8'hfe);
    wr(OFS_MAIN_CTRL, 8'h21);
    repeat (100) if (ov_irq !== 1'b1) @(posedge sys_clk);
    check("ov_irq", {31'h0, ov_irq}, 32'h1);
    rd_chk("ov_flag", OFS_CTRL_STAT, 8'h20);
    wr(OFS_MAIN_CTRL, 8'h00);
    @(posedge sys_clk);
    check("ov_mask", {31'h0, ov_irq}, 32'h0);
    // match a with clear, every output code
    wr(OFS_COUNT, 8'h00);
    wr(OFS_MAIN_CTRL, 8'h49);
    for (int i = 0; i < 5; i++) begin
      wr(OFS_CTRL_STAT, {6'h0, codes[i]});
      @(posedge sys_clk);
      repeat (100) if (irq_a !== 1'b1) @(posedge sys_clk);
      @(posedge sys_clk);
      check("wave_a", {31'h0, wave}, {31'h0, expw[i]});
      check("irq_a", {31'h0, irq_a}, 32'h1);
      // count passes compare b on its way to a, so flag b is set too
      rd_chk("flag_a", OFS_CTRL_STAT, {6'h30, codes[i]});
      cnt_in("clr_a", 8'h00, 8'h02);
    end
    // match b with clear, toggle
    wr(OFS_CTRL_STAT, 8'h0c);
    wr(OFS_MAIN_CTRL, 8'h91);
    wr(OFS_COUNT, 8'h00);
    repeat (200) if (irq_b !== 1'b1) @(posedge sys_clk);
    @(posedge sys_clk);
    check("wave_b", {31'h0, wave}, 32'h1);
    check("irq_b", {31'h0, irq_b}, 32'h1);
    check("irq_a_off", {31'h0, irq_a}, 32'h0);
    cnt_in("clr_b", 8'h00, 8'h02);
    // clear pin, ignored then honoured
    wr(OFS_MAIN_CTRL, 8'h00);
    wr(OFS_COUNT, 8'h40);
    pins.pulse_clr();
    rd_chk("clr_off", OFS_COUNT, 8'h40);
    wr(OFS_MAIN_CTRL, 8'h18);
    pins.pulse_clr();
    rd_chk("clr_pin", OFS_COUNT, 8'h00);
    // internal select bit changes the ratio
    wr(OFS_MAIN_CTRL, 8'h01);
    wr(OFS_TRIG_CTRL, 8'h01);
    wr(OFS_COUNT, 8'h00);
    repeat (64) @(posedge sys_clk);
    cnt_in("div16", 8'h03, 8'h05);
    wr(OFS_TRIG_CTRL, 8'h00);
    wr(OFS_COUNT, 8'h00);
    repeat (64) @(posedge sys_clk);
    cnt_in("div4", 8'h0f, 8'h12);
    // trigger start and halt on clear, every edge mode
    wr(OFS_MAIN_CTRL, 8'h19);
    for (int i = 0; i < 4; i++) begin
      m = modes[i];
      wr(OFS_TRIG_CTRL, {3'h0, m, 3'h4});
      pins.pulse_clr();
      repeat (40) @(posedge sys_clk);
      cnt_in("halt", 8'h00, 8'h00);
      pins.tog_trig();
      hit = (m[0] & trig) | (m[1] & ~trig);
      repeat (40) @(posedge sys_clk);
      cnt_in("trig", {7'h0, hit}, {8{hit}});
      if (!hit) begin
        pins.tog_trig();
        hit = (m != 2'h0);
        repeat (40) @(posedge sys_clk);
        cnt_in("trig2", {7'h0, hit}, {8{hit}});
      end
    end
    // trigger disabled: clear does not halt
    wr(OFS_TRIG_CTRL, 8'h08);
    pins.pulse_clr();
    repeat (40) @(posedge sys_clk);
    cnt_in("no_halt", 8'h01, 8'hff);
    // external count clock, each edge choice
    wr(OFS_TRIG_CTRL, 8'h00);
    for (int i = 0; i < 3; i++) begin
      wr(OFS_MAIN_CTRL, {5'h0, eck[i]});
      wr(OFS_COUNT, 8'h00);
      pins.clk_burst(4);
      repeat (6) @(posedge sys_clk);
      rd_chk("ext", OFS_COUNT, expc[i]);
    end
    conclude();
  end
endmodule
